// File: tmz_timer.sv
`timescale 1ns/100ps
`include "tmz_map.svh"
// Function
// - Source select clear: count every instruction cycle without prescaler.
// - A count write suppresses increments for the next two cycles.
// - Source select set: count edges on the external count input.
// - Edge select clear counts rising edges, set counts falling edges.
// - Prescaler serves timer when assign bit clear, watchdog when set.
// - Ratio field picks 1:2 up to 1:256 for the timer.
// - Prescaler is an 8-bit counter software cannot read or write.
// - With timer assignment, each count write clears the prescaler.
// - With watchdog assignment, watchdog clear also clears the prescaler.
// - Reset forces the prescaler count to zero.
// - Prescaler output is sampled on second and fourth phase clocks.
// - External input is divided by an asynchronous ripple counter only when the prescaler serves the timer.
// - Count changes three to five periods after an input change.
// - Timer count is an 8-bit read/write register, index 1.
module tmz_timer #(
   parameter int PS_WIDTH = 8
) (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   input wire logic i_count_pin,
   input wire logic i_wdt_tick,
   output logic o_wdt_post,
   output logic o_wdt_clear,
   output logic [7:0] o_port_direction,
   output logic [7:0] o_timer_count,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready
);
   logic [7:0] timer_count_reg;
   logic [7:0] option_reg;
   logic [7:0] dir_reg;
   logic [7:0] aw_addr_reg;
   logic aw_have_reg;
   logic [31:0] w_data_reg;
   logic w_have_reg;
   logic w_lane0_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [1:0] inhibit_reg;
   logic pin_s1_reg;
   logic pin_s2_reg;
   logic samp_reg;
   logic samp_prev_reg;
   logic ps_clr_reg;
   logic wdt_clr_reg;
   tmz_pkg::tmz_phase_e phase_reg;
   logic do_write;
   logic wr_count;
   logic wr_option;
   logic wr_dir;
   logic wr_cmd;
   logic src_sel;
   logic edge_sel;
   logic prescaler_assign;
   logic [2:0] ratio;
   logic ps_src;
   logic [PS_WIDTH-1:0] ps_count;
   logic ps_out;
   logic tick_int;
   logic tick_ext;
   logic incr;

   function automatic logic addr_hit(input logic [7:0] a,
      input logic [7:0] off);
      addr_hit = (a[7:2] == off[7:2]);
   endfunction : addr_hit

   assign src_sel = option_reg[`TMZ_OPT_SRC];
   assign edge_sel = option_reg[`TMZ_OPT_EDGE];
   assign prescaler_assign = option_reg[`TMZ_OPT_PSA];
   assign ratio = option_reg[`TMZ_OPT_PS_LSB +: 3];

   // Write channel: address and data are taken in either order.
   assign o_awready = !aw_have_reg && !bvalid_reg;
   assign o_wready = !w_have_reg && !bvalid_reg;
   assign do_write = aw_have_reg && w_have_reg && !bvalid_reg && i_ce;
   assign wr_count = do_write && w_lane0_reg
      && addr_hit(aw_addr_reg, `TMZ_OFF_COUNT);
   assign wr_option = do_write && w_lane0_reg
      && addr_hit(aw_addr_reg, `TMZ_OFF_OPTION);
   assign wr_dir = do_write && w_lane0_reg
      && addr_hit(aw_addr_reg, `TMZ_OFF_DIR);
   assign wr_cmd = do_write && w_lane0_reg
      && addr_hit(aw_addr_reg, `TMZ_OFF_CMD)
      && w_data_reg[`TMZ_CMD_WDT_CLR];

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
      end
      else if (i_ce)
      begin
         if (o_awready && i_awvalid)
         begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= i_awaddr;
         end
         else if (do_write)
            aw_have_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         w_have_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_lane0_reg <= 1'b0;
      end
      else if (i_ce)
      begin
         if (o_wready && i_wvalid)
         begin
            w_have_reg <= 1'b1;
            w_data_reg <= i_wdata;
            w_lane0_reg <= i_wstrb[0];
         end
         else if (do_write)
            w_have_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'b00;
      end
      else if (i_ce)
      begin
         if (do_write)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (addr_hit(aw_addr_reg, `TMZ_OFF_COUNT)
               || addr_hit(aw_addr_reg, `TMZ_OFF_OPTION)
               || addr_hit(aw_addr_reg, `TMZ_OFF_DIR)
               || addr_hit(aw_addr_reg, `TMZ_OFF_CMD)) ? 2'b00 : 2'b10;
         end
         else if (i_bready)
            bvalid_reg <= 1'b0;
      end
   end

   assign o_bvalid = bvalid_reg;
   assign o_bresp = bresp_reg;

   // Prescaler not mapped
   // Read channel: option and direction are write-only and read as zero.
   assign o_arready = !rvalid_reg;

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= 2'b00;
      end
      else if (i_ce)
      begin
         if (o_arready && i_arvalid)
         begin
            rvalid_reg <= 1'b1;
            rresp_reg <= 2'b00;
            rdata_reg <= 32'h00000000;
            if (addr_hit(i_araddr, `TMZ_OFF_COUNT))
               rdata_reg <= {24'h000000, timer_count_reg};
            else if (addr_hit(i_araddr, `TMZ_OFF_STATUS))
               rdata_reg <= {28'h0000000, samp_reg, src_sel, prescaler_assign,
                  inhibit_reg != 2'd0};
            else if (!(addr_hit(i_araddr, `TMZ_OFF_OPTION)
               || addr_hit(i_araddr, `TMZ_OFF_DIR)
               || addr_hit(i_araddr, `TMZ_OFF_CMD)))
               rresp_reg <= 2'b10;
         end
         else if (i_rready)
            rvalid_reg <= 1'b0;
      end
   end

   assign o_rvalid = rvalid_reg;
   assign o_rdata = rdata_reg;
   assign o_rresp = rresp_reg;

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         option_reg <= `TMZ_OPT_RESET;
      else if (i_ce && wr_option)
         option_reg <= w_data_reg[7:0];
   end

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         dir_reg <= `TMZ_DIR_RESET;
      else if (i_ce && wr_dir)
         dir_reg <= {2'b00, w_data_reg[5:0]};
   end

   // Direction bits 7 and 6 are unimplemented and always hold zero.
   assign o_port_direction = dir_reg;

   // Four internal phases make one instruction cycle.
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         phase_reg <= tmz_pkg::TMZ_PH1;
      else if (i_ce)
      begin
         case (phase_reg)
            tmz_pkg::TMZ_PH1: phase_reg <= tmz_pkg::TMZ_PH2;
            tmz_pkg::TMZ_PH2: phase_reg <= tmz_pkg::TMZ_PH3;
            tmz_pkg::TMZ_PH3: phase_reg <= tmz_pkg::TMZ_PH4;
            tmz_pkg::TMZ_PH4: phase_reg <= tmz_pkg::TMZ_PH1;
            default: phase_reg <= tmz_pkg::TMZ_PH1;
         endcase
      end
   end

   assign tick_int = (phase_reg == tmz_pkg::TMZ_PH4);

   // Prescaler source: timer side or watchdog side, never both.
   // Falling edge selected by inverting the pin.
   assign ps_src = prescaler_assign ? i_wdt_tick
      : (src_sel ? (i_count_pin ^ edge_sel) : tick_int);

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         ps_clr_reg <= 1'b0;
         wdt_clr_reg <= 1'b0;
      end
      else if (i_ce)
      begin
         ps_clr_reg <= (wr_count && !prescaler_assign) || (wr_cmd && prescaler_assign);
         wdt_clr_reg <= wr_cmd;
      end
   end

   assign o_wdt_clear = wdt_clr_reg;

   tmz_ripple #(
      .WIDTH(PS_WIDTH)
   ) u_ripple (
      .i_src(ps_src),
      .i_arst_n(i_arst_n),
      .i_clr(ps_clr_reg),
      .o_count(ps_count)
   );

   assign ps_out = ps_count[ratio];
   assign o_wdt_post = prescaler_assign & ps_out;

   // Two-stage sync
   // Reset to the idle level that the reset option sees, a low pin inverted
   // for falling-edge counting, so that no false edge follows reset.
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         pin_s1_reg <= 1'b1;
         pin_s2_reg <= 1'b1;
      end
      else if (i_ce)
      begin
         pin_s1_reg <= (prescaler_assign ? (i_count_pin ^ edge_sel) : ps_out);
         pin_s2_reg <= pin_s1_reg;
      end
   end

   // Sample on second and fourth phase
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         samp_reg <= 1'b1;
         samp_prev_reg <= 1'b1;
      end
      else if (i_ce && (phase_reg == tmz_pkg::TMZ_PH2
         || phase_reg == tmz_pkg::TMZ_PH4))
      begin
         samp_reg <= pin_s2_reg;
         samp_prev_reg <= samp_reg;
      end
   end

   assign tick_ext = samp_reg && !samp_prev_reg
      && (phase_reg == tmz_pkg::TMZ_PH1 || phase_reg == tmz_pkg::TMZ_PH3);

   // Counter mode tick
   // A prescaled timer counts rising edges of the synced tap, not its level.
   assign incr = (src_sel || !prescaler_assign) ? tick_ext : tick_int;

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         inhibit_reg <= 2'd0;
      else if (i_ce)
      begin
         if (wr_count)
            inhibit_reg <= `TMZ_INHIBIT_CYCLES;
         else if (tick_int && inhibit_reg != 2'd0)
            inhibit_reg <= inhibit_reg - 2'd1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         timer_count_reg <= 8'h00;
      else if (i_ce)
      begin
         if (wr_count)
            timer_count_reg <= w_data_reg[7:0];
         else if (incr && inhibit_reg == 2'd0)
            timer_count_reg <= timer_count_reg + 8'h01;
      end
   end

   assign o_timer_count = timer_count_reg;
endmodule : tmz_timer

// File: tmz_map.svh
`ifndef TMZ_MAP_SVH
`define TMZ_MAP_SVH
`define TMZ_OFF_COUNT 8'h04
`define TMZ_OFF_OPTION 8'h08
`define TMZ_OFF_DIR 8'h0c
`define TMZ_OFF_CMD 8'h10
`define TMZ_OFF_STATUS 8'h14
`define TMZ_OPT_PS_LSB 0
`define TMZ_OPT_PSA 3
`define TMZ_OPT_EDGE 4
`define TMZ_OPT_SRC 5
`define TMZ_OPT_RESET 8'hff
`define TMZ_DIR_RESET 8'h3f
`define TMZ_CMD_WDT_CLR 0
`define TMZ_INHIBIT_CYCLES 2'd2
`define TMZ_PHASES 4
`endif

// File: tmz_pkg.sv
package tmz_pkg;
   typedef enum logic [1:0] {
      TMZ_PH1 = 2'b00,
      TMZ_PH2 = 2'b01,
      TMZ_PH3 = 2'b11,
      TMZ_PH4 = 2'b10
   } tmz_phase_e;
endpackage : tmz_pkg

// File: tmz_ripple.sv
`timescale 1ns/100ps
// Divides a source by two per stage; each stage is clocked by the one below.
module tmz_ripple #(
   parameter int WIDTH = 8
) (
   input wire logic i_src,
   input wire logic i_arst_n,
   input wire logic i_clr,
   output logic [WIDTH-1:0] o_count
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_stage
         logic stage_reg;
         if (g == 0)
         begin : g_first
            always_ff @(posedge i_src or negedge i_arst_n or posedge i_clr)
            begin
               if (!i_arst_n || i_clr)
                  stage_reg <= 1'b0;
               else
                  stage_reg <= ~stage_reg;
            end
         end
         else
         begin : g_next
            always_ff @(negedge g_stage[g-1].stage_reg or negedge i_arst_n
               or posedge i_clr)
            begin
               if (!i_arst_n || i_clr)
                  stage_reg <= 1'b0;
               else
                  stage_reg <= ~stage_reg;
            end
         end
         assign o_count[g] = g_stage[g].stage_reg;
      end
   endgenerate
endmodule : tmz_ripple

// File: tmz_src.sv
`timescale 1ns/100ps
// Far-side count source; it rests low between bursts.
module tmz_src (
   input wire logic i_mclk,
   input wire logic i_go,
   input wire logic [3:0] i_pulses,
   output logic o_pin,
   output logic o_done
);
   initial
   begin
      o_pin = 1'b0;
      o_done = 1'b0;
   end
   always @(posedge i_go)
   begin
      o_done = 1'b0;
      repeat (i_pulses)
      begin
         repeat (8) @(posedge i_mclk);
         o_pin <= 1'b1;
         repeat (8) @(posedge i_mclk);
         o_pin <= 1'b0;
      end
      o_done <= 1'b1;
   end
endmodule : tmz_src

// File: tmz_timer_props.sv
`timescale 1ns/100ps
`include "tmz_map.svh"
module tmz_chk #(
   parameter int PS_WIDTH = 8
) (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic o_rvalid,
   input wire logic o_wdt_post,
   input wire logic o_wdt_clear,
   input wire logic [7:0] o_timer_count
);
   logic [7:0] aw_q;
   logic [7:0] w_q;
   logic [7:0] opt_q;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   // Shadows the last write so responses can be tied to their cause.
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         aw_q <= 8'h00;
         w_q <= 8'h00;
         opt_q <= `TMZ_OPT_RESET;
      end
      else
      begin
         if (i_awvalid && o_awready)
            aw_q <= i_awaddr;
         if (i_wvalid && o_wready)
            w_q <= i_wdata[7:0];
         if (o_bvalid && i_bready && aw_q == `TMZ_OFF_OPTION)
            opt_q <= w_q;
      end
   end
   property p_bhold;
      o_bvalid && !i_bready |=> o_bvalid;
   endproperty
   a_bhold: assert property (p_bhold) else $error("bvalid dropped");
   property p_rans;
      i_arvalid && o_arready |=> o_rvalid;
   endproperty
   a_rans: assert property (p_rans) else $error("no read answer");
   property p_wval;
      $rose(o_bvalid) && aw_q == `TMZ_OFF_COUNT |-> o_timer_count == w_q;
   endproperty
   a_wval: assert property (p_wval) else $error("count not written");
   property p_inhib;
      $rose(o_bvalid) && aw_q == `TMZ_OFF_COUNT
         |=> $stable(o_timer_count) [*7];
   endproperty
   a_inhib: assert property (p_inhib) else $error("count moved early");
   property p_step;
      $changed(o_timer_count) && !$rose(o_bvalid)
         |-> o_timer_count == $past(o_timer_count) + 8'h01;
   endproperty
   a_step: assert property (p_step) else $error("count step bad");
   property p_wrap;
      $past(o_timer_count) == 8'hff && !$rose(o_bvalid)
         |-> o_timer_count inside {8'hff, 8'h00};
   endproperty
   a_wrap: assert property (p_wrap) else $error("count wrap bad");
   property p_post;
      !opt_q[`TMZ_OPT_PSA] && !o_bvalid |-> !o_wdt_post;
   endproperty
   a_post: assert property (p_post) else $error("post while timer");
   property p_clr;
      $rose(o_bvalid) && aw_q == `TMZ_OFF_CMD && w_q[0] |-> ##[0:2] o_wdt_clear;
   endproperty
   a_clr: assert property (p_clr) else $error("no watchdog clear");
endmodule : tmz_chk
bind tmz_timer tmz_chk #(.PS_WIDTH(PS_WIDTH)) u_chk (.i_mclk, .i_arst_n,
   .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wvalid, .o_wready,
   .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rvalid, .o_wdt_post,
   .o_wdt_clear, .o_timer_count);

// File: tb.sv
`timescale 1ns/100ps
`include "tmz_map.svh"
module tb;
   logic i_mclk = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_wdt_tick = 1'b0;
   logic [7:0] i_awaddr = 8'h00;
   logic [7:0] i_araddr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic [3:0] i_wstrb = 4'hf;
   logic i_awvalid = 1'b0;
   logic i_wvalid = 1'b0;
   logic i_bready = 1'b0;
   logic i_arvalid = 1'b0;
   logic i_rready = 1'b0;
   logic go = 1'b0;
   logic [3:0] npul = 4'h0;
   logic pin, done, o_wdt_post, o_wdt_clear, o_awready, o_wready;
   logic o_bvalid, o_arready, o_rvalid;
   logic [1:0] o_bresp, o_rresp, rr, br;
   logic [7:0] o_port_direction, o_timer_count, s0;
   logic [31:0] o_rdata, rv;
   int mismatches = 0;
   int n_checks = 0;
   always #2.5 i_mclk = ~i_mclk;
   always @(posedge i_mclk) i_wdt_tick <= ~i_wdt_tick;
   tmz_timer uut (.i_ce(1'b1), .i_count_pin(pin), .*);
   tmz_src u_src (.i_mclk, .i_go(go), .i_pulses(npul), .o_pin(pin),
      .o_done(done));
   task automatic close_out;
      if (mismatches == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [7:0] s, e);
      n_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, d);
      @(posedge i_mclk);
      i_awaddr <= a;
      i_wdata <= {24'h000000, d};
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      do
      begin
         @(posedge i_mclk);
         if (o_awready)
            i_awvalid <= 1'b0;
         if (o_wready)
            i_wvalid <= 1'b0;
      end while (!o_bvalid);
      br = o_bresp;
      i_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge i_mclk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do
      begin
         @(posedge i_mclk);
         if (o_arready)
            i_arvalid <= 1'b0;
      end while (!o_rvalid);
      rv = o_rdata;
      rr = o_rresp;
      i_rready <= 1'b0;
   endtask : rd
   // Clears the count, sends a burst and stops two cycles after its end.
   task automatic pulse(input logic [3:0] n);
      wr(`TMZ_OFF_COUNT, 8'h00);
      npul <= n;
      go <= 1'b1;
      @(posedge i_mclk);
      go <= 1'b0;
      do
      begin
         @(posedge i_mclk);
      end while (!done);
      @(posedge i_mclk);
   endtask : pulse
   initial
   begin
      repeat (60000) @(posedge i_mclk);
      mismatches++;
      close_out();
   end
   initial
   begin
      repeat (8) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      chk("dir", o_port_direction, `TMZ_DIR_RESET);
      rd(`TMZ_OFF_COUNT);
      chk("count", rv[7:0], 8'h00);
      rd(8'h40);
      chk("resp", {6'h00, rr}, 8'h02);
      rd(`TMZ_OFF_OPTION);
      chk("opt", rv[7:0], 8'h00);
      rd(`TMZ_OFF_STATUS);
      chk("status", rv[7:0], 8'h0e);
      wr(8'h40, 8'h00);
      chk("bresp", {6'h00, br}, 8'h02);
      wr(`TMZ_OFF_DIR, 8'h15);
      chk("dir", o_port_direction, 8'h15);
      wr(`TMZ_OFF_OPTION, 8'h08);
      wr(`TMZ_OFF_COUNT, 8'hfe);
      repeat (7) @(posedge i_mclk);
      chk("inhibit", o_timer_count, 8'hfe);
      repeat (17) @(posedge i_mclk);
      chk("wrap", o_timer_count, 8'h02);
      // watchdog clear before the prescaler moves to the timer
      wr(`TMZ_OFF_CMD, 8'h01);
      for (int k = 0; k < 8; k++)
      begin
         wr(`TMZ_OFF_OPTION, 8'(k));
         wr(`TMZ_OFF_COUNT, 8'h00);
         repeat ((16 << k) + 40) @(posedge i_mclk);
         s0 = o_timer_count;
         repeat (64 << k) @(posedge i_mclk);
         s0 = o_timer_count - s0;
         chk("ratio", {7'h00, s0 >= 8'h07 && s0 <= 8'h09}, 8'h01);
      end
      // quiet move of the prescaler from timer to watchdog
      wr(`TMZ_OFF_CMD, 8'h01);
      wr(`TMZ_OFF_COUNT, 8'h00);
      wr(`TMZ_OFF_OPTION, 8'h28);
      wr(`TMZ_OFF_CMD, 8'h01);
      wr(`TMZ_OFF_OPTION, 8'h28);
      pulse(4'h5);
      chk("rise", o_timer_count, 8'h05);
      wr(`TMZ_OFF_OPTION, 8'h38);
      pulse(4'h5);
      chk("fall", o_timer_count, 8'h04);
      repeat (10) @(posedge i_mclk);
      chk("late", o_timer_count, 8'h05);
      // watchdog clear before the prescaler moves to the timer
      wr(`TMZ_OFF_CMD, 8'h01);
      wr(`TMZ_OFF_OPTION, 8'h20);
      pulse(4'h8);
      repeat (10) @(posedge i_mclk);
      chk("ripple", o_timer_count, 8'h04);
      close_out();
   end
endmodule : tb
